// ==== bench/flash_prog_monitor.sv ====
module flash_prog_monitor
  import flash_prog_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Pin levels
  input wire logic resetPin,
  input wire logic addrLatchPin,
  input wire logic program_store_strobe_n,
  input wire logic mode_select_first,
  input wire logic mode_select_second,
  input wire logic mode_select_third,
  input wire logic mode_select_fourth,
  input wire logic chipSelect_n,
  input wire logic outputGate_n,
  input wire supply_t external_access_pin,
  // Data enables
  input wire logic dataHostOe,
  input wire logic dataDevOe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // Decoded pin combinations
  // ----------------------------------------
  logic quiet, readLv, pvLv, evLv, outLv;
  assign quiet = resetPin && !addrLatchPin && program_store_strobe_n && !mode_select_second &&
    !mode_select_third && !mode_select_fourth;
  assign readLv = quiet && !mode_select_first && !chipSelect_n && !outputGate_n &&
    external_access_pin == SUPPLY_LOGIC_HIGH;
  assign pvLv = quiet && !mode_select_first && chipSelect_n && !outputGate_n &&
    external_access_pin == SUPPLY_PROGRAM;
  assign evLv = quiet && mode_select_first && chipSelect_n && !outputGate_n &&
    external_access_pin == SUPPLY_ERASE;
  assign outLv = readLv || pvLv || evLv;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_read; readLv |=> dataDevOe; endproperty
  a_read: assert property (p_read) else $error("read levels gave no drive");
  property p_gate; outputGate_n |=> !dataDevOe; endproperty
  a_gate: assert property (p_gate) else $error("data driven with gate high");
  property p_inhibit; (chipSelect_n && outputGate_n) [*2] |-> !dataDevOe; endproperty
  a_inhibit: assert property (p_inhibit) else $error("data driven while inhibited");
  property p_pverify; pvLv |=> dataDevOe; endproperty
  a_pverify: assert property (p_pverify) else $error("program verify gave no drive");
  property p_everify; evLv |=> dataDevOe; endproperty
  a_everify: assert property (p_everify) else $error("erase verify gave no drive");
  property p_unlisted; !outLv |=> !dataDevOe; endproperty
  a_unlisted: assert property (p_unlisted) else $error("drive on unlisted levels");
  property p_cause; $rose(dataDevOe) |-> $past(outLv); endproperty
  a_cause: assert property (p_cause) else $error("drive without output levels");
  property p_contend; !(dataHostOe && dataDevOe); endproperty
  a_contend: assert property (p_contend) else $error("both ends drive data");
  property p_hostdrive;
    !chipSelect_n && outputGate_n && external_access_pin inside {SUPPLY_PROGRAM, SUPPLY_ERASE} |-> dataHostOe;
  endproperty
  a_hostdrive: assert property (p_hostdrive) else $error("host not driving write data");
endmodule

// ==== bench/tb_top.sv ====
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_prog_pkg::*;
  localparam int DEPTH = 64;
  logic core_clk = 0, reset = 1, cmdValid = 0, rspValid, rspMismatch;
  op_t cmdOp = OP_IDLE;
  logic [15:0] cmdAddr = 16'h0000;
  logic [7:0] cmdData = 8'h00, rspData, sec;
  logic [7:0] mem [DEPTH];
  int mismatches = 0, tests_run = 0, cycles = 0;
  // Clock
  always #4 core_clk = ~core_clk;
  flash_prog_if pinsIf();
  flash_prog_device #(.DEPTH(DEPTH)) flash_prog_device_inst (.core_clk(core_clk), .reset(reset), .pins(pinsIf));
  flash_prog_host flash_prog_host_inst (.core_clk(core_clk), .reset(reset), .cmdValid(cmdValid), .cmdOp(cmdOp),
    .cmdAddr(cmdAddr), .cmdData(cmdData), .rspValid(rspValid), .rspData(rspData), .rspMismatch(rspMismatch),
    .pins(pinsIf));
  flash_prog_monitor flash_prog_monitor_inst (.core_clk(core_clk), .reset(reset), .resetPin(pinsIf.resetPin),
    .addrLatchPin(pinsIf.addrLatchPin), .program_store_strobe_n(pinsIf.program_store_strobe_n),
    .mode_select_first(pinsIf.mode_select_first), .mode_select_second(pinsIf.mode_select_second),
    .mode_select_third(pinsIf.mode_select_third), .mode_select_fourth(pinsIf.mode_select_fourth),
    .chipSelect_n(pinsIf.chipSelect_n), .outputGate_n(pinsIf.outputGate_n),
    .external_access_pin(pinsIf.external_access_pin), .dataHostOe(pinsIf.dataHostOe),
    .dataDevOe(pinsIf.dataDevOe));
  // Expected byte seen on a read
  function logic [7:0] expRead(input logic [15:0] a);
    if (a == SECURITY_ADDR) return sec;
    if (a >= DEPTH) return ERASED_BYTE;
    if (!sec[LOCK_BIT_POS]) return LOCKED_READ_BYTE;
    return mem[a];
  endfunction
  task check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task final_report;
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One command, answer checked against the model
  task run(input op_t op, input logic [15:0] a, input logic [7:0] d);
    int n;
    logic [7:0] e, cmp;
    n = 0;
    cmdOp = op;
    cmdAddr = a;
    cmdData = d;
    cmdValid = 1'b1;
    @(posedge core_clk);
    #1 cmdValid = 1'b0;
    while (rspValid !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1 n++;
    end
    if (op == OP_ERASE) begin
      foreach (mem[i]) mem[i] = ERASED_BYTE;
      sec = SECURITY_RESET;
    end else if (op == OP_PROGRAM && a == SECURITY_ADDR) sec &= d;
    else if (op == OP_PROGRAM && a < DEPTH) mem[a] &= d;
    e = expRead(a);
    cmp = (op inside {OP_ERASE, OP_ERASE_VERIFY}) ? ERASED_BYTE : d;
    check(16'(n), (op inside {OP_PROGRAM, OP_ERASE}) ? 16'h0005 : 16'h0003);
    check(16'(rspData), 16'(e));
    if (op != OP_READ) check(16'(rspMismatch), 16'(e !== cmp));
  endtask
  // Cycle ceiling
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      final_report;
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [15:0] a;
    void'($urandom(29438));
    repeat (5) @(posedge core_clk);
    #1 reset = 1'b0;
    run(OP_ERASE, 16'h0000, 8'hFF);
    for (int i = 0; i < DEPTH; i++) run(OP_ERASE_VERIFY, 16'(i), 8'hFF);
    repeat (60) begin
      a = 16'($urandom_range(DEPTH - 1));
      run(OP_PROGRAM, a, 8'($urandom));
      run($urandom_range(1) ? OP_READ : OP_PROGRAM_VERIFY, a, 8'($urandom));
    end
    run(OP_PROGRAM, 16'h0005, 8'h0F);
    run(OP_PROGRAM, 16'h0005, 8'hF0);
    run(OP_PROGRAM, 16'h0040, 8'h00);
    run(OP_READ, 16'h8000, 8'h00);
    run(OP_PROGRAM, SECURITY_ADDR, 8'hFE);
    run(OP_READ, 16'h0005, 8'h00);
    run(OP_PROGRAM, SECURITY_ADDR, 8'hFF);
    run(OP_READ, SECURITY_ADDR, 8'h00);
    run(OP_ERASE, 16'h0000, 8'hFF);
    run(OP_READ, 16'h0005, 8'h00);
    final_report;
  end
endmodule

// ==== shared/flash_prog_if.sv ====
interface flash_prog_if;
  import flash_prog_pkg::*;
  // Mode-entry pins
  logic resetPin;
  logic addrLatchPin;
  logic program_store_strobe_n;
  // Mode-control pins
  logic mode_select_first;
  logic mode_select_second;
  logic mode_select_third;
  logic mode_select_fourth;
  logic chipSelect_n;
  logic outputGate_n;
  // Supply pin level
  supply_t external_access_pin;
  // Address ports
  logic [7:0] addrHigh;
  logic [7:0] addrLow;
  // Data port, split per end
  logic [7:0] dataFromHost;
  logic dataHostOe;
  logic [7:0] dataFromDev;
  logic dataDevOe;

  modport device (
    input resetPin, addrLatchPin, program_store_strobe_n,
    input mode_select_first, mode_select_second, mode_select_third, mode_select_fourth,
    input chipSelect_n, outputGate_n, external_access_pin, addrHigh, addrLow,
    input dataFromHost, dataHostOe,
    output dataFromDev, dataDevOe
  );
  modport host (
    output resetPin, addrLatchPin, program_store_strobe_n,
    output mode_select_first, mode_select_second, mode_select_third, mode_select_fourth,
    output chipSelect_n, outputGate_n, external_access_pin, addrHigh, addrLow,
    output dataFromHost, dataHostOe,
    input dataFromDev, dataDevOe
  );
endinterface

// ==== shared/flash_prog_pkg.sv ====
package flash_prog_pkg;
  // ----------------------------------------
  // Array geometry
  // ----------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int ARRAY_DEPTH = 32768;
  localparam logic [15:0] SECURITY_ADDR = 16'hFFFF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] SECURITY_RESET = 8'hFF;
  localparam int LOCK_BIT_POS = 0;
  localparam logic [7:0] LOCKED_READ_BYTE = 8'hFF;

  // Levels on the programming-supply input
  typedef enum logic [1:0] {
    SUPPLY_LOGIC_LOW,
    SUPPLY_LOGIC_HIGH,
    SUPPLY_PROGRAM,
    SUPPLY_ERASE
  } supply_t;

  // Operations a programmer can ask for
  typedef enum logic [2:0] {
    OP_IDLE,
    OP_READ,
    OP_PROGRAM,
    OP_PROGRAM_VERIFY,
    OP_ERASE,
    OP_ERASE_VERIFY
  } op_t;
endpackage

// ==== src/flash_prog_device.sv ====
// Summary of operation
// R1 - Operation chosen only by static pin levels
// R2 - 16-bit address, 8-bit bidirectional data
// R3 - Read drives stored byte onto data
// R4 - Lock bit active hides true contents
// R5 - Output gate high keeps data undriven
// R6 - Program at program level stores byte
// R7 - Programmer reads back each programmed byte
// R8 - Erase sets all cells and security high
// R9 - Programming only clears bits to zero
// R10 - Programmer erase-verifies every byte reads FF; after an erase the host erase-verifies only address 0000
// R11 - Chip select and gate high inhibit
// R12 - Security register reachable only here
// R13 - Security register at top address
// R14 - Programmed security bits stay low; reset here sets security_r back to SECURITY_RESET
// R15 - Security bit zero is lock, active-low
// R16 - Unlisted combinations change and drive nothing
module flash_prog_device
  import flash_prog_pkg::*;
#(
  parameter int DEPTH = ARRAY_DEPTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Programming pins
  flash_prog_if.device pins
);
  localparam int IDX_W = $clog2(DEPTH);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  // Array must be a power of two and leave the top address free
  if (DEPTH < 2 || DEPTH > 32768 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("DEPTH must be a power of two from 2 to 32768");
  end

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  // Applied address and its region
  logic [15:0] addr;
  logic inArray;
  logic isSecurity;
  logic [IDX_W-1:0] cellIdx;
  // Level groups on the control pins
  logic modeEntry;
  logic controlsQuiet;
  logic supplyHigh;
  logic supplyProgram;
  logic supplyErase;
  logic inhibited;
  logic readLevels;
  logic programLevels;
  logic programVerifyLevels;
  logic eraseLevels;
  logic eraseVerifyLevels;
  op_t op;
  // Write strobes
  logic eraseAll;
  logic arrayWrite;
  logic securityWrite;
  // Storage
  logic [7:0] mem_r [DEPTH];
  logic [7:0] security_r;
  logic lockActive;
  // Data port
  logic outputOp;
  logic [7:0] storedByte;
  logic [7:0] readByte;
  logic [7:0] dataOut_r;
  logic dataOe_r;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  // Two 8-bit ports form one byte address
  assign addr = {pins.addrHigh, pins.addrLow}; // [R2]
  assign cellIdx = addr[IDX_W-1:0];
  assign isSecurity = (addr == SECURITY_ADDR); // [R13]
  assign inArray = (addr < 16'(DEPTH)); // Above the array reads erased

  // ----------------------------------------
  // Pin level decode
  // ----------------------------------------
  // Mode entry levels on reset, address latch and strobe
  assign modeEntry = pins.resetPin && !pins.addrLatchPin && pins.program_store_strobe_n; // [R12]
  // Second and fourth mode selects stay low in every operation
  assign controlsQuiet = modeEntry && !pins.mode_select_second && !pins.mode_select_fourth; // [R1]
  // Supply pin levels
  assign supplyHigh = (pins.external_access_pin == SUPPLY_LOGIC_HIGH);
  assign supplyProgram = (pins.external_access_pin == SUPPLY_PROGRAM);
  assign supplyErase = (pins.external_access_pin == SUPPLY_ERASE);
  // Both selects high leaves this part out of shared programming
  assign inhibited = pins.chipSelect_n && pins.outputGate_n; // [R11]

  // One term for each listed operation
  assign readLevels = controlsQuiet && !pins.mode_select_first && !pins.mode_select_third
                      && !pins.chipSelect_n && !pins.outputGate_n && supplyHigh; // [R3]
  assign programLevels = controlsQuiet && !pins.mode_select_first && !pins.mode_select_third
                         && !pins.chipSelect_n && pins.outputGate_n && supplyProgram; // [R6]
  assign programVerifyLevels = controlsQuiet && !pins.mode_select_first && !pins.mode_select_third
                               && pins.chipSelect_n && !pins.outputGate_n && supplyProgram;
  assign eraseLevels = controlsQuiet && pins.mode_select_first && pins.mode_select_third
                       && !pins.chipSelect_n && pins.outputGate_n && supplyErase
                       && !pins.addrLow[0] && pins.dataFromHost == ERASED_BYTE; // [R8]
  assign eraseVerifyLevels = controlsQuiet && pins.mode_select_first && !pins.mode_select_third
                             && pins.chipSelect_n && !pins.outputGate_n && supplyErase;

  // Priority chain names the operation; anything else is idle
  always_comb begin
    op = OP_IDLE; // [R16]
    if (inhibited) begin
      op = OP_IDLE; // [R11]
    end else if (readLevels) begin
      op = OP_READ; // [R3]
    end else if (programLevels) begin
      op = OP_PROGRAM; // [R6]
    end else if (programVerifyLevels) begin
      op = OP_PROGRAM_VERIFY;
    end else if (eraseLevels) begin
      op = OP_ERASE; // [R8]
    end else if (eraseVerifyLevels) begin
      op = OP_ERASE_VERIFY;
    end
  end

  // ----------------------------------------
  // Write strobes
  // ----------------------------------------
  assign eraseAll = (op == OP_ERASE); // [R8]
  // Top address goes to the security register, never to a cell
  assign arrayWrite = (op == OP_PROGRAM) && inArray && !isSecurity; // [R13]
  assign securityWrite = (op == OP_PROGRAM) && isSecurity; // [R13]

  // ----------------------------------------
  // Array and security storage
  // ----------------------------------------
  // Cells keep contents across reset, like real flash
  always_ff @(posedge core_clk) begin
    if (eraseAll) begin // [R8]
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= ERASED_BYTE;
      end
    end else if (arrayWrite) begin
      mem_r[cellIdx] <= mem_r[cellIdx] & pins.dataFromHost; // [R9]
    end
  end

  // Security register, program can only clear bits
  always_ff @(posedge core_clk) begin
    if (reset) begin
      security_r <= SECURITY_RESET;
    end else if (eraseAll) begin
      security_r <= SECURITY_RESET; // [R8]
    end else if (securityWrite) begin
      security_r <= security_r & pins.dataFromHost; // [R14]
    end
  end

  // Lock bit is active low
  assign lockActive = !security_r[LOCK_BIT_POS]; // [R15]

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Operations that put a byte on the data port
  assign outputOp = (op == OP_READ) || (op == OP_PROGRAM_VERIFY) || (op == OP_ERASE_VERIFY);

  // Byte at the applied address
  always_comb begin
    storedByte = ERASED_BYTE;
    if (isSecurity) begin
      storedByte = security_r;
    end else if (inArray) begin
      storedByte = mem_r[cellIdx];
    end
  end

  // Lock hides cell contents but not the security register itself
  always_comb begin
    readByte = storedByte; // [R3]
    if (lockActive && !isSecurity) begin
      readByte = LOCKED_READ_BYTE; // [R4]
    end
  end

  // ----------------------------------------
  // Data port drive
  // ----------------------------------------
  // Output enable follows the gate only during output operations
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dataOe_r <= 1'b0;
    end else if (outputOp) begin
      dataOe_r <= !pins.outputGate_n; // [R5]
    end else begin
      dataOe_r <= 1'b0; // [R5] [R16]
    end
  end

  // Output byte, cleared when not driving to keep the port quiet
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dataOut_r <= 8'h00;
    end else if (outputOp) begin
      dataOut_r <= readByte;
    end else begin
      dataOut_r <= 8'h00;
    end
  end

  // Both port signals come straight from flip-flops
  assign pins.dataFromDev = dataOut_r;
  assign pins.dataDevOe = dataOe_r;
endmodule

// ==== src/flash_prog_host.sv ====
module flash_prog_host
  import flash_prog_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // User command
  input wire logic cmdValid,
  input wire op_t cmdOp,
  input wire logic [15:0] cmdAddr,
  input wire logic [7:0] cmdData,
  // User result
  output logic rspValid,
  output logic [7:0] rspData,
  output logic rspMismatch,
  // Pins
  flash_prog_if.host pins
);
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  typedef enum logic [2:0] {IDLE, APPLY, SETTLE, SAMPLE, VERIFY} state_t;
  state_t state_r;
  op_t op_r;
  logic [15:0] addr_r;
  logic [7:0] data_r;
  logic rspValid_r;
  logic [7:0] rspData_r;
  logic rspMismatch_r;
  logic cs_n_r;
  logic oe_n_r;
  logic ms1_r;
  logic ms3_r;
  supply_t supply_r;
  logic drive_r;

  // Each op: apply levels, then sample; program and erase add a verify step
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r <= IDLE;
      op_r <= OP_IDLE;
      addr_r <= 16'h0000;
      data_r <= 8'h00;
      rspValid_r <= 1'b0;
      rspData_r <= 8'h00;
      rspMismatch_r <= 1'b0;
    end else begin
      rspValid_r <= 1'b0;
      case (state_r)
        IDLE: begin
          if (cmdValid) begin
            op_r <= cmdOp;
            addr_r <= (cmdOp == OP_ERASE) ? 16'h0000 : cmdAddr; // [R8]
            data_r <= (cmdOp inside {OP_ERASE, OP_ERASE_VERIFY}) ? ERASED_BYTE : cmdData; // [R8] [R10]
            state_r <= APPLY;
          end
        end
        APPLY: begin
          state_r <= SETTLE;
        end
        // Device registers its answer here; program and erase move on to verify levels
        SETTLE: begin
          if (op_r == OP_PROGRAM || op_r == OP_ERASE) begin
            op_r <= (op_r == OP_PROGRAM) ? OP_PROGRAM_VERIFY : OP_ERASE_VERIFY; // [R7] [R10]
            state_r <= VERIFY;
          end else begin
            state_r <= SAMPLE;
          end
        end
        // Registered device byte has settled by now
        SAMPLE: begin
          rspValid_r <= 1'b1;
          rspData_r <= pins.dataFromDev;
          rspMismatch_r <= (op_r == OP_PROGRAM_VERIFY || op_r == OP_ERASE_VERIFY)
                           && (pins.dataFromDev != data_r); // [R7] [R10]
          state_r <= IDLE;
        end
        VERIFY: begin
          state_r <= SETTLE;
        end
        default: state_r <= IDLE;
      endcase
    end
  end

  // Static pin levels for the current operation
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cs_n_r <= 1'b1;
      oe_n_r <= 1'b1; // [R11]
      ms1_r <= 1'b0;
      ms3_r <= 1'b0;
      supply_r <= SUPPLY_LOGIC_HIGH;
      drive_r <= 1'b0;
    end else if (state_r == IDLE) begin
      cs_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      ms1_r <= 1'b0;
      ms3_r <= 1'b0;
      supply_r <= SUPPLY_LOGIC_HIGH;
      drive_r <= 1'b0;
    end else begin
      case (op_r)
        OP_READ: begin
          {cs_n_r, oe_n_r, ms1_r, ms3_r, drive_r} <= 5'b00000; // [R1] [R3]
          supply_r <= SUPPLY_LOGIC_HIGH;
        end
        OP_PROGRAM: begin
          {cs_n_r, oe_n_r, ms1_r, ms3_r, drive_r} <= 5'b01001; // [R6]
          supply_r <= SUPPLY_PROGRAM;
        end
        OP_PROGRAM_VERIFY: begin
          {cs_n_r, oe_n_r, ms1_r, ms3_r, drive_r} <= 5'b10000; // [R7]
          supply_r <= SUPPLY_PROGRAM;
        end
        OP_ERASE: begin
          {cs_n_r, oe_n_r, ms1_r, ms3_r, drive_r} <= 5'b01111; // [R8]
          supply_r <= SUPPLY_ERASE;
        end
        OP_ERASE_VERIFY: begin
          {cs_n_r, oe_n_r, ms1_r, ms3_r, drive_r} <= 5'b10100; // [R10]
          supply_r <= SUPPLY_ERASE;
        end
        default: begin
          {cs_n_r, oe_n_r, ms1_r, ms3_r, drive_r} <= 5'b11000;
          supply_r <= SUPPLY_LOGIC_HIGH;
        end
      endcase
    end
  end

  // Mode entry levels held constant
  assign pins.resetPin = 1'b1;
  assign pins.addrLatchPin = 1'b0;
  assign pins.program_store_strobe_n = 1'b1;
  assign pins.mode_select_first = ms1_r;
  assign pins.mode_select_second = 1'b0;
  assign pins.mode_select_third = ms3_r;
  assign pins.mode_select_fourth = 1'b0;
  assign pins.chipSelect_n = cs_n_r;
  assign pins.outputGate_n = oe_n_r;
  assign pins.external_access_pin = supply_r;
  assign pins.addrHigh = addr_r[15:8];
  assign pins.addrLow = addr_r[7:0];
  assign pins.dataFromHost = data_r;
  assign pins.dataHostOe = drive_r;
  assign rspValid = rspValid_r;
  assign rspData = rspData_r;
  assign rspMismatch = rspMismatch_r;
endmodule
